// [inc/adcsp_chan_if.sv]
`timescale 1ns/1ns
interface adcsp_chan_if;
  logic                                mod_tick;
  logic                                sinc_tick;
  logic                                lpf_load;
  logic                                lpf_first;
  logic                                lpf_last;
  logic                                enable;
  logic                                mod_bit;
  logic signed [adcsp_pkg::SAMPLE_W-1:0] sinc_data;
  logic signed [adcsp_pkg::SAMPLE_W-1:0] dec_data;

  modport ctrl (
    output mod_tick, sinc_tick, lpf_load, lpf_first, lpf_last, enable, mod_bit,
    input  sinc_data, dec_data
  );
  modport chain (
    input  mod_tick, sinc_tick, lpf_load, lpf_first, lpf_last, enable, mod_bit,
    output sinc_data, dec_data
  );
endinterface

// [inc/adcsp_pkg.sv]
package adcsp_pkg;

  // Channel layout.
  localparam int CH_N       = 7;
  localparam int NEUTRAL_CH = 6;
  localparam int GAIN_W     = 2;

  // Clock rates and the decimation chain.
  localparam int       IN_CLK_HZ  = 12288000;
  localparam int       MOD_CLK_HZ = 1024000;
  localparam int       MOD_DIV    = IN_CLK_HZ / MOD_CLK_HZ;
  localparam int       SINC_DECIM = 64;
  localparam int       LPF_DECIM  = 4;
  localparam logic [3:0] MOD_LAST  = 4'(MOD_DIV - 1);
  localparam logic [5:0] SINC_LAST = 6'(SINC_DECIM - 1);
  localparam logic [1:0] LPF_LAST  = 2'(LPF_DECIM - 1);

  // Datapath widths and scaling.
  localparam int CIC_W     = 26;
  localparam int SINC_DROP = 2;
  localparam int SAMPLE_W  = 24;
  localparam int ACC_W     = 26;
  localparam int PROD_W    = 38;
  localparam int WORD_W    = 32;
  localparam int FMT_SHIFT = 4;
  localparam logic signed [11:0] LPF_GAIN = 12'sh471;
  localparam int LPF_SHIFT = 12;

  // Setting codes.
  localparam logic [1:0] PIN_SEL_READY = 2'h3;
  localparam logic [1:0] GAIN_X1       = 2'h0;
  localparam logic [1:0] GAIN_X2       = 2'h1;
  localparam logic [1:0] GAIN_X4       = 2'h2;

  typedef enum logic [1:0] {
    full_power_mode     = 2'b00,
    reduced_power_mode  = 2'b01,
    tamper_compare_mode = 2'b10,
    sleep_power_mode    = 2'b11
  } adcsp_psm_t;

  typedef enum logic {
    wf_sinc_rate  = 1'b0,
    wf_decim_rate = 1'b1
  } adcsp_wfsrc_t;

endpackage

// [src/adcsp_path_ctrl.sv]
`timescale 1ns/1ns
// Operation
// R1 - Each channel runs continuously unless its bit in the channel off mask is set.
// R2 - Full power mode powers and runs all seven channels.
// R3 - Reduced power mode runs three current and three voltage channels, neutral off.
// R4 - Power modes two and three hold every channel off regardless of settings.
// R5 - A completed conversion sets the sample set ready flag to one.
// R6 - Pin select code 11 makes the shared pin pulse per fresh sample set.
// R7 - Ready rate follows the stream picked by the waveform source select.
// R8 - Modulator clock is the input clock divided by twelve, 1.024 MHz.
// R9 - Sinc4 stage decimates modulator rate by 64, giving 16 kHz.
// R10 - Low-pass decimator divides the sinc4 rate by four, giving 4 kHz.
// R11 - Stored samples are shifted left four bits and sign extended to 32.
// R12 - A 1 V peak input yields about 4,190,000 from the sinc4 stage.
// R13 - A 1 V peak input yields about 4,660,000 from the decimator stage.
// R14 - Host sets external reference select; device then disables its reference buffer.
// R15 - Clock output is inverted digital input clock, only in power modes zero, one.
// R16 - Each channel has a gain of 1, 2 or 4 from its gain field.
// R17 - All seven channels sample at the same instant.
// R18 - A disabled channel presents zero samples downstream.
module adcsp_path_ctrl (
  // Clock and reset
  input  wire logic                                          clk,
  input  wire logic                                          reset_n,
  // Configuration
  input  wire logic [1:0]                                    power_mode,
  input  wire logic [adcsp_pkg::CH_N-1:0]                    channel_off_mask,
  input  wire logic [adcsp_pkg::CH_N*adcsp_pkg::GAIN_W-1:0]  channel_gain_word,
  input  wire logic                                          waveform_source_select,
  input  wire logic [1:0]                                    multipurpose_pin_select,
  input  wire logic                                          external_reference_select,
  input  wire logic                                          clock_is_digital,
  input  wire logic                                          sample_ready_clear,
  // Analog front end and clock pins
  input  wire logic [adcsp_pkg::CH_N-1:0]                    mod_bits_in,
  input  wire logic                                          clock_input_pin,
  output logic [adcsp_pkg::CH_N-1:0]                         channel_power,
  output logic [adcsp_pkg::CH_N*adcsp_pkg::GAIN_W-1:0]       channel_gain_word_ctrl,
  output logic                                               ref_buffer_on,
  output logic                                               clock_output_pin,
  // Status and results
  output logic                                               sample_set_ready,
  output logic                                               shared_event_pin,
  output logic [adcsp_pkg::CH_N*adcsp_pkg::WORD_W-1:0]       sample_words
);

  logic [adcsp_pkg::CH_N-1:0]                    mod_s1_reg;
  logic [adcsp_pkg::CH_N-1:0]                    mod_s2_reg;
  logic                                          clock_input_pin_s1_reg;
  logic                                          clock_input_pin_s2_reg;
  logic [3:0]                                    mod_cnt_reg;
  logic [5:0]                                    sinc_cnt_reg;
  logic [1:0]                                    lpf_cnt_reg;
  logic                                          sinc_load_reg;
  logic                                          dec_done_reg;
  logic [adcsp_pkg::CH_N-1:0]                    power_reg;
  logic [adcsp_pkg::CH_N*adcsp_pkg::GAIN_W-1:0]  gain_reg;
  logic                                          ref_buf_reg;
  logic                                          clock_output_pin_reg;
  logic                                          ready_reg;
  logic                                          pin_reg;
  logic [adcsp_pkg::CH_N*adcsp_pkg::WORD_W-1:0]  words_reg;
  logic [adcsp_pkg::CH_N-1:0]                    power_next;
  logic [adcsp_pkg::CH_N*adcsp_pkg::GAIN_W-1:0]  gain_next;
  logic [adcsp_pkg::CH_N*adcsp_pkg::WORD_W-1:0]  words_next;
  logic                                          mod_tick;
  logic                                          sinc_tick;
  logic                                          lpf_last;
  logic                                          use_dec;
  logic                                          store;
  logic                                          mode_full;
  logic                                          mode_reduced;
  logic                                          clock_output_pin_next;

  // Rate dividers shared by every channel.
  assign mod_tick     = (mod_cnt_reg == adcsp_pkg::MOD_LAST);                  // [R8]
  assign sinc_tick    = mod_tick && (sinc_cnt_reg == adcsp_pkg::SINC_LAST);    // [R9]
  assign lpf_last     = (lpf_cnt_reg == adcsp_pkg::LPF_LAST);                  // [R10]
  assign use_dec      = (waveform_source_select == adcsp_pkg::wf_decim_rate);
  assign store        = use_dec ? dec_done_reg : sinc_load_reg;                // [R7]
  assign mode_full    = (power_mode == adcsp_pkg::full_power_mode);
  assign mode_reduced = (power_mode == adcsp_pkg::reduced_power_mode);
  assign clock_output_pin_next  = clock_is_digital && (mode_full || mode_reduced)
                        && !clock_input_pin_s2_reg;                                      // [R15]

  // Per-channel gating, gain decode, decimation chain and word formatting.
  for (genvar i = 0; i < adcsp_pkg::CH_N; i++)
  begin : g_ch
    adcsp_chan_if chan ();
    logic                                  allow;
    logic [1:0]                            gcode;
    logic signed [adcsp_pkg::SAMPLE_W-1:0] pick;

    assign allow = mode_full                                                   // [R2]
                   || (mode_reduced && (i != adcsp_pkg::NEUTRAL_CH));          // [R3] [R4]
    assign power_next[i] = allow && !channel_off_mask[i];                      // [R1]
    assign gcode = channel_gain_word[i*adcsp_pkg::GAIN_W +: adcsp_pkg::GAIN_W];
    assign gain_next[i*adcsp_pkg::GAIN_W +: adcsp_pkg::GAIN_W] =
      (gcode == adcsp_pkg::GAIN_X2 || gcode == adcsp_pkg::GAIN_X4) ? gcode
                                                                   : adcsp_pkg::GAIN_X1;  // [R16]
    assign chan.mod_tick  = mod_tick;                                          // [R17]
    assign chan.sinc_tick = sinc_tick;                                         // [R17]
    assign chan.lpf_load  = sinc_load_reg;
    assign chan.lpf_first = (lpf_cnt_reg == 2'h0);
    assign chan.lpf_last  = lpf_last;
    assign chan.enable    = power_reg[i];
    assign chan.mod_bit   = mod_s2_reg[i];
    assign pick = use_dec ? chan.dec_data : chan.sinc_data;
    assign words_next[i*adcsp_pkg::WORD_W +: adcsp_pkg::WORD_W] =
      {{(adcsp_pkg::WORD_W-adcsp_pkg::SAMPLE_W-adcsp_pkg::FMT_SHIFT){pick[adcsp_pkg::SAMPLE_W-1]}},
       pick, 4'h0};                                                            // [R11]

    adcsp_sinc_chain u_chain (
      .clk     (clk),
      .reset_n (reset_n),
      .ch      (chan.chain)
    );
  end

  // Input synchronisers.
  always_ff @(posedge clk)
  begin
    mod_s1_reg   <= mod_bits_in;
    mod_s2_reg   <= mod_s1_reg;
    clock_input_pin_s1_reg <= clock_input_pin;
    clock_input_pin_s2_reg <= clock_input_pin_s1_reg;
  end

  // Divider counters and stage strobes.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mod_cnt_reg   <= 4'h0;
      sinc_cnt_reg  <= 6'h00;
      lpf_cnt_reg   <= 2'h0;
      sinc_load_reg <= 1'b0;
      dec_done_reg  <= 1'b0;
    end
    else
    begin
      mod_cnt_reg   <= mod_tick ? 4'h0 : mod_cnt_reg + 4'h1;
      if (mod_tick)
        sinc_cnt_reg <= sinc_cnt_reg + 6'h01;
      if (sinc_load_reg)
        lpf_cnt_reg <= lpf_cnt_reg + 2'h1;
      sinc_load_reg <= sinc_tick;
      dec_done_reg  <= sinc_load_reg && lpf_last;
    end
  end

  // Control outputs, status flag, pin pulse and result words.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      power_reg   <= '0;
      gain_reg    <= '0;
      ref_buf_reg <= 1'b0;
      clock_output_pin_reg  <= 1'b0;
      ready_reg   <= 1'b0;
      pin_reg     <= 1'b0;
      words_reg   <= '0;
    end
    else
    begin
      power_reg   <= power_next;
      gain_reg    <= gain_next;
      ref_buf_reg <= !external_reference_select;                               // [R14]
      clock_output_pin_reg  <= clock_output_pin_next;
      ready_reg   <= store || (ready_reg && !sample_ready_clear);              // [R5]
      pin_reg     <= store && (multipurpose_pin_select == adcsp_pkg::PIN_SEL_READY);  // [R6]
      if (store)
        words_reg <= words_next;
    end
  end

  assign channel_power    = power_reg;
  assign channel_gain_word_ctrl    = gain_reg;
  assign ref_buffer_on    = ref_buf_reg;
  assign clock_output_pin = clock_output_pin_reg;
  assign sample_set_ready = ready_reg;
  assign shared_event_pin = pin_reg;
  assign sample_words     = words_reg;

  // Helper counters for the rate checks.
  logic [6:0] mods_seen_reg;
  logic [2:0] sincs_seen_reg;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mods_seen_reg  <= 7'h00;
      sincs_seen_reg <= 3'h0;
    end
    else
    begin
      if (sinc_tick)
        mods_seen_reg <= 7'h00;
      else if (mod_tick)
        mods_seen_reg <= mods_seen_reg + 7'h01;
      if (dec_done_reg)
        sincs_seen_reg <= 3'h0;
      else if (sinc_load_reg)
        sincs_seen_reg <= sincs_seen_reg + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chan_mask_a: assert property (                                               // [R1]
    channel_off_mask[0] |=> !channel_power[0])
    else $error("Masked channel still powered.");
  full_mode_a: assert property (                                               // [R2]
    (mode_full && channel_off_mask == '0) |=> (channel_power == 7'h7F))
    else $error("Full power mode did not power all channels.");
  neutral_off_a: assert property (                                             // [R3]
    mode_reduced |=> !channel_power[adcsp_pkg::NEUTRAL_CH])
    else $error("Neutral channel on in reduced mode.");
  low_power_off_a: assert property (                                           // [R4]
    power_mode[1] |=> (channel_power == '0))
    else $error("Channel on in mode two or three.");
  ready_set_a: assert property (                                               // [R5]
    store |=> sample_set_ready)
    else $error("Ready flag not set after a conversion.");
  pin_pulse_a: assert property (                                               // [R6]
    shared_event_pin |-> $past(store) && !$past(shared_event_pin)
      && ($past(multipurpose_pin_select) == adcsp_pkg::PIN_SEL_READY))
    else $error("Event pin pulse without a fresh sample set.");
  mod_period_a: assert property (                                              // [R8]
    mod_tick |=> !mod_tick [*8] ##1 !mod_tick [*3] ##1 mod_tick)
    else $error("Modulator tick period is not twelve cycles.");
  sinc_ratio_a: assert property (                                              // [R9]
    sinc_tick |-> (mods_seen_reg == {1'b0, adcsp_pkg::SINC_LAST}))
    else $error("Sinc stage ratio is not 64.");
  dec_ratio_a: assert property (                                               // [R10] [R7]
    (dec_done_reg |-> (sincs_seen_reg == 3'(adcsp_pkg::LPF_DECIM)))
      and (store |-> (use_dec ? (sincs_seen_reg == 3'(adcsp_pkg::LPF_DECIM))
                              : (mods_seen_reg == 7'h00))))
    else $error("Decimator ratio is not four.");
  word_fmt_a: assert property (                                                // [R11]
    store |=> (sample_words[3:0] == 4'h0)
      && (sample_words[31:27] == {5{sample_words[27]}}))
    else $error("Stored word not shifted and sign extended.");
  clock_output_pin_mode_a: assert property (                                             // [R15]
    clock_output_pin |-> $past(mode_full || mode_reduced) && $past(clock_is_digital))
    else $error("Clock output active outside modes zero and one.");

endmodule  // adcsp_path_ctrl

// [src/adcsp_sinc_chain.sv]
`timescale 1ns/1ns
module adcsp_sinc_chain (
  // Clock and reset
  input wire logic   clk,
  input wire logic   reset_n,
  // Channel link to the controller
  adcsp_chan_if.chain ch
);

  logic signed [adcsp_pkg::CIC_W-1:0]    integ_reg [4];
  logic signed [adcsp_pkg::CIC_W-1:0]    dly_reg   [4];
  logic signed [adcsp_pkg::CIC_W-1:0]    comb_w    [5];
  logic signed [adcsp_pkg::SAMPLE_W-1:0] sinc_reg;
  logic signed [adcsp_pkg::SAMPLE_W-1:0] dec_reg;
  logic signed [adcsp_pkg::ACC_W-1:0]    acc_reg;
  logic signed [adcsp_pkg::ACC_W-1:0]    acc_base;
  logic signed [adcsp_pkg::ACC_W-1:0]    acc_sum;
  logic signed [adcsp_pkg::PROD_W-1:0]   prod_w;
  logic signed [adcsp_pkg::CIC_W-1:0]    step_w;

  // A one bit counts as plus one, a zero bit as minus one.
  assign step_w = {{(adcsp_pkg::CIC_W-1){~ch.mod_bit}}, 1'b1};
  assign comb_w[0] = integ_reg[3];
  for (genvar k = 0; k < 4; k++)
  begin : g_comb
    assign comb_w[k+1] = comb_w[k] - dly_reg[k];
  end
  assign acc_base = ch.lpf_first ? '0 : acc_reg;
  assign acc_sum  = acc_base + adcsp_pkg::ACC_W'(sinc_reg);
  assign prod_w   = acc_sum * adcsp_pkg::LPF_GAIN;

  // Fourth-order integrate and comb, then average four results with gain trim.
  always_ff @(posedge clk)
  begin
    if (!reset_n || !ch.enable)
    begin
      for (int k = 0; k < 4; k++)
      begin
        integ_reg[k] <= '0;
        dly_reg[k]   <= '0;
      end
      sinc_reg <= '0;  // [R18]
      dec_reg  <= '0;  // [R18]
      acc_reg  <= '0;
    end
    else
    begin
      if (ch.mod_tick)
      begin
        integ_reg[0] <= integ_reg[0] + step_w;
        for (int k = 1; k < 4; k++)
          integ_reg[k] <= integ_reg[k] + integ_reg[k-1];
      end
      if (ch.sinc_tick)
      begin
        for (int k = 0; k < 4; k++)
          dly_reg[k] <= comb_w[k];
        sinc_reg <= comb_w[4][adcsp_pkg::CIC_W-1:adcsp_pkg::SINC_DROP];  // [R9] [R12]
      end
      if (ch.lpf_load)
        acc_reg <= acc_sum;
      if (ch.lpf_load && ch.lpf_last)
        dec_reg <= prod_w[adcsp_pkg::LPF_SHIFT +: adcsp_pkg::SAMPLE_W];  // [R10] [R13]
    end
  end

  assign ch.sinc_data = sinc_reg;
  assign ch.dec_data  = dec_reg;

  off_zero_a: assert property (  // [R18]
    @(posedge clk) disable iff (!reset_n)
    !ch.enable |=> (ch.sinc_data == '0) && (ch.dec_data == '0))
    else $error("Disabled channel shows a nonzero sample.");

endmodule  // adcsp_sinc_chain

// [verification/adcsp_far_end.sv]
`timescale 1ns/1ns
// Behavioural modulator and digital clock source in front of the converter.
module adcsp_far_end (
  // Clock
  input  wire logic                       clk,
  // Channel stimulus
  input  wire logic [adcsp_pkg::CH_N-1:0] pos_mask,
  input  wire logic [adcsp_pkg::CH_N-1:0] mid_mask,
  // Pins toward the converter
  output logic      [adcsp_pkg::CH_N-1:0] mod_bits,
  output logic                            clk_pin
);
  int   div_cnt = 0;
  logic alt     = 1'b0;
  logic pin_q   = 1'b0;

  // A mid channel flips once per modulator period, so it averages to zero.
  always @(negedge clk)
  begin
    div_cnt <= (div_cnt == 11) ? 0 : div_cnt + 1;
    if (div_cnt == 11)
      alt <= ~alt;
    if (div_cnt % 3 == 0)
      pin_q <= ~pin_q;
  end

  assign mod_bits = (mid_mask & {adcsp_pkg::CH_N{alt}}) | (~mid_mask & pos_mask);
  assign clk_pin  = pin_q;
endmodule // adcsp_far_end

// [verification/testbench.sv]
`timescale 1ns/1ns
module testbench;
  localparam int N = adcsp_pkg::CH_N;
  logic           clk = 1'b0;
  logic           reset_n = 1'b0;
  logic [1:0]     power_mode = 2'h0;
  logic [N-1:0]   channel_off_mask = '0;
  logic [2*N-1:0] channel_gain_word = '0;
  logic           waveform_source_select = 1'b0;
  logic [1:0]     multipurpose_pin_select = 2'h0;
  logic           external_reference_select = 1'b0;
  logic           clock_is_digital = 1'b0;
  logic           sample_ready_clear = 1'b0;
  logic [N-1:0]   pos_mask = '0;
  logic [N-1:0]   mid_mask = '0;
  logic [N-1:0]   mod_bits_in;
  logic           clock_input_pin;
  logic [N-1:0]   channel_power;
  logic [2*N-1:0] channel_gain_word_ctrl;
  logic           ref_buffer_on;
  logic           clock_output_pin;
  logic           sample_set_ready;
  logic           shared_event_pin;
  logic [32*N-1:0] sample_words;
  int             bad_count = 0;
  int             n_compared = 0;
  int             gap;
  logic [2*N-1:0] exp_gain;
  logic           seen;

  adcsp_path_ctrl u_adcsp_path_ctrl (.clk(clk), .reset_n(reset_n), .power_mode(power_mode),
    .channel_off_mask(channel_off_mask), .channel_gain_word(channel_gain_word),
    .waveform_source_select(waveform_source_select),
    .multipurpose_pin_select(multipurpose_pin_select),
    .external_reference_select(external_reference_select),
    .clock_is_digital(clock_is_digital), .sample_ready_clear(sample_ready_clear),
    .mod_bits_in(mod_bits_in), .clock_input_pin(clock_input_pin),
    .channel_power(channel_power), .channel_gain_word_ctrl(channel_gain_word_ctrl),
    .ref_buffer_on(ref_buffer_on), .clock_output_pin(clock_output_pin),
    .sample_set_ready(sample_set_ready), .shared_event_pin(shared_event_pin),
    .sample_words(sample_words));

  adcsp_far_end u_adcsp_far_end (.clk(clk), .pos_mask(pos_mask), .mid_mask(mid_mask),
    .mod_bits(mod_bits_in), .clk_pin(clock_input_pin));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
  begin
    n_compared++;
    if (exp !== got)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  task automatic end_of_test;
  begin
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  task automatic wait_pulse(output int g);
  begin
    g = 0;
    while (shared_event_pin !== 1'b1)
    begin
      @(negedge clk);
      g++;
      if (g > 4000)
      begin
        bad_count++;
        $display("mismatch event_pulse expected pulse seen none");
        end_of_test();
      end
    end
  end
  endtask

  // Channels allowed by the power mode, less those switched off.
  function automatic logic [N-1:0] model_power(input logic [1:0] m, input logic [N-1:0] off);
    logic [N-1:0] allowed;
    allowed = (m == 2'h0) ? 7'h7F : ((m == 2'h1) ? 7'h3F : 7'h00);
    return allowed & ~off;
  endfunction

  // Settled full-scale, zero or negative sample per channel, scaled into a stored word.
  function automatic logic [255:0] model_words(input logic [N-1:0] on, input logic src);
    logic [255:0] w;
    longint       v;
    w = '0;
    for (int i = 0; i < N; i++)
    begin
      v = mid_mask[i] ? 0 : (pos_mask[i] ? 64'sd4194304 : -64'sd4194304);
      if (src)
        v = (v * 1137) / 1024;
      if (!on[i])
        v = 0;
      w[32*i +: 32] = 32'(v * 16);
    end
    return w;
  endfunction

  initial
  begin
    void'($urandom(32'h2DC2A5D4));
    repeat (6) @(negedge clk);
    check("reset_outputs", 256'h0, 256'({channel_power, channel_gain_word_ctrl, sample_set_ready}));
    reset_n = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      power_mode = 2'(m);
      channel_off_mask = 7'($urandom);
      channel_gain_word = 14'($urandom);
      external_reference_select = 1'($urandom);
      for (int i = 0; i < N; i++)
        exp_gain[2*i +: 2] = (channel_gain_word[2*i +: 2] == 2'h3) ?
                             2'h0 : channel_gain_word[2*i +: 2];
      repeat (2) @(negedge clk);
      check("channel_power", 256'(model_power(2'(m), channel_off_mask)),
            256'(channel_power));
      check("channel_gain_word_ctrl", 256'(exp_gain), 256'(channel_gain_word_ctrl));
      check("ref_buffer_on", 256'(!external_reference_select), 256'(ref_buffer_on));
    end
    $display("test config done");
    for (int k = 0; k < 8; k++)
    begin
      power_mode = 2'(k);
      clock_is_digital = k[2];
      repeat (4) @(negedge clk);
      seen = 1'b0;
      repeat (40)
      begin
        @(negedge clk);
        seen = seen | (clock_output_pin === 1'b1);
      end
      check("clock_output_toggle", 256'(k[2] && k[1] == 1'b0), 256'(seen));
    end
    $display("test clock output done");
    for (int p = 0; p < 2; p++)
    begin
      power_mode = 2'(p);
      waveform_source_select = p[0];
      multipurpose_pin_select = adcsp_pkg::PIN_SEL_READY;
      channel_off_mask = 7'($urandom & $urandom);
      pos_mask = 7'($urandom);
      mid_mask = 7'($urandom & $urandom);
      for (int k = 0; k < 10; k++)
      begin
        wait_pulse(gap);
        if (k > 1)
          check("store_spacing", 256'(p ? 3072 : 768), 256'(gap + 1));
        if (k > 6)
        begin
          check("sample_words", model_words(model_power(2'(p), channel_off_mask), p[0]),
                256'(sample_words));
          check("ready_flag", 256'h1, 256'(sample_set_ready));
        end
        @(negedge clk);
        check("event_pin_width", 256'h0, 256'(shared_event_pin));
      end
    end
    $display("test sample stream done");
    waveform_source_select = 1'b0;
    multipurpose_pin_select = 2'(2'h1 + ($urandom % 2));
    sample_ready_clear = 1'b1;
    @(negedge clk);
    sample_ready_clear = 1'b0;
    check("ready_cleared", 256'h0, 256'(sample_set_ready));
    seen = 1'b0;
    repeat (800)
    begin
      @(negedge clk);
      seen = seen | (shared_event_pin === 1'b1);
    end
    check("event_pin_quiet", 256'h0, 256'(seen));
    check("ready_without_pin", 256'h1, 256'(sample_set_ready));
    $display("test pin select done");
    end_of_test();
  end
endmodule // testbench
